// ==== smstx_defines.svh ====
// Constants for the synchronous master serial transmitter.
// Behaviour
// (R1) Half duplex: receive blocks transmit.
// (R2) Mode select bit 4 enters synchronous mode.
// (R3) Port enable bit 7 claims both pins.
// (R4) Clock source bit 7 makes us master.
// (R5) Shifter reloads only after last bit.
// (R6) Hand-off takes one cycle, sets empty flag.
// (R7) Empty flag clears only on buffer write.
// (R8) Interrupt request gated by enable bit 4.
// (R9) Read-only shifter empty status, bit 1.
// (R10) Transmit enable arms; buffer load starts.
// (R11) Data changes on rising shift clock edge.
// (R12) Rate generator reset while all enables clear.
// (R13) Transmit enable starts shift clock immediately.
// (R14) Empty shifter takes write at once; back-to-back.
// (R15) Clearing transmit enable aborts, floats both pins; the clock pin stays driven while a receive enable is set.
// (R16) Receive enable aborts, floats data, keeps state.
// (R17) Single receive ends, transmit resumes driving data.
// (R18) Ninth bit select sends bit 0 value.
// (R19) Software writes ninth bit before data.
// (R20) Software follows the documented setup order.
// (R21) Shift register is not software visible.
// (R22) Shift clock is clock over 4(divisor+1).
// (R23) Divisor write clears rate generator timer.
// (R24) Least significant bit first, ninth last.
`ifndef SMSTX_DEFINES_SVH
`define SMSTX_DEFINES_SVH
`define SMSTX_TXCTL_ADDR 4'h0
`define SMSTX_RXCTL_ADDR 4'h4
`define SMSTX_DIV_ADDR 4'h8
`define SMSTX_BUF_ADDR 4'hC
`define SMSTX_FLAG_ADDR 5'h10
`define SMSTX_IEN_ADDR 5'h14
`define SMSTX_RXDONE_ADDR 5'h18
`define SMSTX_TX_CLOCK_SOURCE_MASTER 7
`define SMSTX_TX_NINE 6
`define SMSTX_TX_EN 5
`define SMSTX_TX_SYNC 4
`define SMSTX_TX_EMPTY 1
`define SMSTX_TX_D9 0
`define SMSTX_RX_SERIAL_PORT_ENABLE 7
`define SMSTX_RX_SINGLE_RECEIVE_ENABLE 5
`define SMSTX_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define SMSTX_FLAG_BIT 4
`define SMSTX_RESP_OKAY 2'b00
`define SMSTX_RESP_SLVERR 2'b10
`define SMSTX_DATA_BITS 4'h8
`define SMSTX_FRAME9_BITS 4'h9
`endif

// ==== smstx_pkg.sv ====
// Types for the synchronous master serial transmitter.
package smstx_pkg;
  typedef struct packed {
    logic clock_source_master;
    logic nine;
    logic transmit_enable;
    logic sync;
    logic d9;
  } smstx_txctl_type;
  typedef struct packed {
    logic serial_port_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
  } smstx_rxctl_type;
endpackage

// ==== smstx_top.sv ====
// Synchronous master serial transmitter with an AXI4-Lite register slave.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "smstx_defines.svh"
module smstx_top #(
  parameter int ADDR_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_word_done,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic tx_irq
);

  // ****************************************
  // Register state
  // ****************************************
  smstx_pkg::smstx_txctl_type ctl;
  smstx_pkg::smstx_rxctl_type rxc;
  logic [7:0] baud_divisor;
  logic [7:0] tx_holding_buffer;
  logic tx_buffer_empty_flag;
  logic tx_buffer_empty_irq_enable;
  logic [8:0] tx_shift_register;
  logic [3:0] bits_left;
  logic shifter_empty_status;
  logic [8:0] brg_count;
  logic [8:0] half_count;
  logic sclk;
  logic tx_data_bit;
  logic div_written;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic buf_write;
  logic rx_active;
  logic brg_run;
  logic tick_rise;
  logic load_shifter;

  // Receive enables both override transmit in synchronous mode.
  assign rx_active = rxc.single_receive_enable | rxc.continuous_receive_enable;
  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign buf_write = do_write && aw_addr == ADDR_W'(`SMSTX_BUF_ADDR) && w_strb[0];

  // Address and data are captured in either order, then answered together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SMSTX_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready;
      s_axi_wready <= ~w_held & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > ADDR_W'(`SMSTX_RXDONE_ADDR) || aw_addr[1:0] != 2'b00) ?
          `SMSTX_RESP_SLVERR : `SMSTX_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Software writable registers
  // ****************************************
  // Only byte lane 0 carries register data; the shift register has no address.
  // (R21) no shifter mapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= '0;
      rxc <= '0;
      baud_divisor <= 8'h00;
      tx_buffer_empty_irq_enable <= 1'b0;
      div_written <= 1'b0;
    end else begin
      div_written <= 1'b0;
      // (R17) single receive self-clears
      if (rx_word_done && rxc.single_receive_enable) begin
        rxc.single_receive_enable <= 1'b0;
      end
      if (do_write && w_strb[0]) begin
        unique case (aw_addr)
          ADDR_W'(`SMSTX_TXCTL_ADDR): begin
            ctl.clock_source_master <= w_data[`SMSTX_TX_CLOCK_SOURCE_MASTER];
            ctl.nine <= w_data[`SMSTX_TX_NINE];
            ctl.transmit_enable <= w_data[`SMSTX_TX_EN];
            ctl.sync <= w_data[`SMSTX_TX_SYNC];
            ctl.d9 <= w_data[`SMSTX_TX_D9];
          end
          ADDR_W'(`SMSTX_RXCTL_ADDR): begin
            rxc.serial_port_enable <= w_data[`SMSTX_RX_SERIAL_PORT_ENABLE];
            rxc.single_receive_enable <= w_data[`SMSTX_RX_SINGLE_RECEIVE_ENABLE];
            rxc.continuous_receive_enable <= w_data[`SMSTX_RX_CONTINUOUS_RECEIVE_ENABLE];
          end
          ADDR_W'(`SMSTX_DIV_ADDR): begin
            baud_divisor <= w_data[7:0];
            div_written <= 1'b1;
          end
          ADDR_W'(`SMSTX_IEN_ADDR): begin
            tx_buffer_empty_irq_enable <= w_data[`SMSTX_FLAG_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SMSTX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid ? 1'b1 :
        (~s_axi_rvalid & ~s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SMSTX_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        unique case (s_axi_araddr)
          ADDR_W'(`SMSTX_TXCTL_ADDR): begin
            // (R9) shifter empty readback
            s_axi_rdata[7:0] <= {ctl.clock_source_master, ctl.nine, ctl.transmit_enable, ctl.sync, 2'b00,
              shifter_empty_status, ctl.d9};
          end
          ADDR_W'(`SMSTX_RXCTL_ADDR): begin
            s_axi_rdata[7:0] <= {rxc.serial_port_enable, 1'b0, rxc.single_receive_enable, rxc.continuous_receive_enable, 4'h0};
          end
          ADDR_W'(`SMSTX_DIV_ADDR): begin
            s_axi_rdata[7:0] <= baud_divisor;
          end
          ADDR_W'(`SMSTX_BUF_ADDR): begin
            s_axi_rdata[7:0] <= tx_holding_buffer;
          end
          ADDR_W'(`SMSTX_FLAG_ADDR): begin
            s_axi_rdata[`SMSTX_FLAG_BIT] <= tx_buffer_empty_flag;
          end
          ADDR_W'(`SMSTX_IEN_ADDR): begin
            s_axi_rdata[`SMSTX_FLAG_BIT] <= tx_buffer_empty_irq_enable;
          end
          ADDR_W'(`SMSTX_RXDONE_ADDR): begin
          end
          default: begin
            s_axi_rresp <= `SMSTX_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Baud rate generator
  // ****************************************
  // (R12) generator held in reset
  assign brg_run = ctl.sync & ctl.clock_source_master & (ctl.transmit_enable | rx_active);
  // The last count of a half period is 2*divisor+1, so each half lasts 2(divisor+1) clocks.
  assign half_count = {baud_divisor, 1'b1};
  assign tick_rise = brg_run && !div_written && brg_count == half_count && !sclk;

  // The system clock is the oscillator clock, so a full shift clock is 4(divisor+1) clocks.
  // A divisor of zero still gives a clean shift clock of four system clocks.
  // The counter is one bit wider than the divisor to hold the doubled half period.
  // (R22) divisor sets rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_count <= 9'h000;
      sclk <= 1'b0;
    end else if (!brg_run || div_written) begin
      // (R23) divisor write clears timer
      brg_count <= 9'h000;
      if (!brg_run) begin
        sclk <= 1'b0;
      end
    end else if (brg_count == half_count) begin
      // (R13) clock starts on enable
      brg_count <= 9'h000;
      sclk <= ~sclk;
    end else begin
      brg_count <= brg_count + 9'h001;
    end
  end

  // ****************************************
  // Holding buffer and empty flag
  // ****************************************
  // Hand-off happens in any cycle with transmit enabled and no receive active, in which the shifter has no bits left and the buffer holds a word.
  // (R10) loaded buffer starts transmission
  // (R5) reload after last bit
  assign load_shifter = ctl.transmit_enable && !rx_active && !tx_buffer_empty_flag &&
    shifter_empty_status;

  // A buffer write landing with a hand-off still keeps its new data pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_buffer <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
    end else if (buf_write) begin
      // (R7) only a buffer write clears
      tx_holding_buffer <= w_data[7:0];
      tx_buffer_empty_flag <= 1'b0;
    end else if (load_shifter) begin
      // (R6) one-cycle hand-off sets flag
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  // ****************************************
  // Shift register
  // ****************************************
  // (R14) immediate pass-through, no gaps
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl.transmit_enable) begin
      // (R15) abort resets transmitter
      tx_shift_register <= 9'h000;
      bits_left <= 4'h0;
      shifter_empty_status <= 1'b1;
      tx_data_bit <= 1'b0;
    end else if (load_shifter) begin
      // (R18) ninth bit sampled here
      tx_shift_register <= {ctl.d9, tx_holding_buffer};
      bits_left <= ctl.nine ? `SMSTX_FRAME9_BITS : `SMSTX_DATA_BITS;
      shifter_empty_status <= 1'b0;
    end else if (tick_rise && !rx_active && !shifter_empty_status) begin
      // Each rising tick puts the next bit on the line; the last bit stays there until
      // the following rise, so a reload in between costs neither a gap nor a bit.
      // (R24) least significant bit first
      // (R11) data advances at rising edge
      tx_data_bit <= tx_shift_register[0];
      tx_shift_register <= {1'b0, tx_shift_register[8:1]};
      bits_left <= bits_left - 4'h1;
      if (bits_left == 4'h1) begin
        shifter_empty_status <= 1'b1;
      end
    end
  end

  // ****************************************
  // Pin drivers and interrupt
  // ****************************************
  // Both pins pass through one register, so data and clock move on the same edge.
  // (R3) pins claimed by port enable
  // (R1) receive blocks transmit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_line_o <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      serial_data_line_o <= 1'b0;
      serial_data_line_oe <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      // (R4) master drives clock
      // (R2) synchronous mode only
      serial_clock_line_o <= sclk;
      serial_clock_line_oe <= rxc.serial_port_enable & ctl.sync & ctl.clock_source_master & (ctl.transmit_enable | rx_active);
      // (R16) receive floats data
      serial_data_line_o <= tx_data_bit;
      serial_data_line_oe <= rxc.serial_port_enable & ctl.sync & ctl.transmit_enable & ~rx_active;
      // (R8) gated interrupt request
      tx_irq <= tx_buffer_empty_flag & tx_buffer_empty_irq_enable;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // (R7) flag clears only by write
  chk_flag_clear_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(tx_buffer_empty_flag) |-> $past(buf_write)) else $error("empty flag fell without write");
  // (R6) hand-off sets flag
  chk_handoff_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    load_shifter && !buf_write |=> tx_buffer_empty_flag && !shifter_empty_status)
    else $error("hand-off did not set flag");
  // (R8) interrupt gating
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_irq |-> $past(tx_buffer_empty_irq_enable)) else $error("irq without enable");
  // (R15) abort floats pins
  chk_abort_float: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.transmit_enable && !rx_active |=> !serial_data_line_oe && !serial_clock_line_oe)
    else $error("pins driven after abort");
  // (R16) receive floats data
  chk_rx_float: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_active |=> !serial_data_line_oe) else $error("data driven during receive");
  // (R12) generator held
  chk_brg_held: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl.transmit_enable && !rx_active |=> brg_count == 9'h000 && !sclk) else $error("generator ran");
  // (R9) status tracks shifter
  chk_empty_status: assert property (@(posedge aclk) disable iff (!aresetn)
    shifter_empty_status |-> bits_left == 4'h0) else $error("status wrong");
  // (R18) ninth bit framing
  chk_nine_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    load_shifter && ctl.nine |=> bits_left == 4'd9) else $error("ninth bit lost");
  // Pin checks look at the registered outputs that the far side really sees.
  // (R11) data steady at falling edge
  chk_data_at_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(serial_clock_line_o) && serial_data_line_oe |-> $stable(serial_data_line_o))
    else $error("data moved at falling clock");
  // (R2) pins only in synchronous mode
  chk_pins_sync_only: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_clock_line_oe || serial_data_line_oe |-> $past(ctl.sync && rxc.serial_port_enable))
    else $error("pin driven outside synchronous mode");
  // (R23) divisor write restarts timer
  chk_div_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    div_written |=> brg_count == 9'h000)
    else $error("timer kept running after divisor write");
  // (R17) single receive self-clears
  chk_single_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_word_done && rxc.single_receive_enable && !(do_write && aw_addr == ADDR_W'(`SMSTX_RXCTL_ADDR))
    |=> !rxc.single_receive_enable) else $error("single receive stayed set");
  // (R14) write to idle shifter passes
  chk_pass_through: assert property (@(posedge aclk) disable iff (!aresetn)
    buf_write && tx_buffer_empty_flag && shifter_empty_status && ctl.transmit_enable && !rx_active
    |=> load_shifter) else $error("idle shifter did not take the word");
  // (R13) shift clock starts at once
  sequence smstx_brg_start;
    $rose(brg_run);
  endsequence
  chk_clock_starts: assert property (@(posedge aclk)
    disable iff (!aresetn || !brg_run || div_written)
    smstx_brg_start |-> ##[1:520] tick_rise) else $error("shift clock did not start");
endmodule

// ==== smstx_slave_model.sv ====
// Behavioural serial slave that collects bits on falling shift clock edges.
`timescale 1ns/1ps
module smstx_slave_model (
  input wire logic aclk,
  input wire logic ck_o,
  input wire logic ck_oe,
  input wire logic dt_o,
  input wire logic dt_oe,
  input wire logic arm,
  input wire logic [4:0] nbits,
  output logic [15:0] word,
  output logic done,
  output int period
);
  logic ck_hold = 1'b0;
  logic dt_hold = 1'b0;
  logic ck_prev = 1'b0;
  logic seen_rise = 1'b0;
  logic ck_line;
  logic dt_line;
  int cnt = 0;
  int since = 0;
  initial begin
    word = 16'h0000;
    done = 1'b0;
    period = 0;
  end
  // No pulls are fitted, so a released line shows the inverse of its last level.
  assign ck_line = ck_oe ? ck_o : ~ck_hold;
  assign dt_line = dt_oe ? dt_o : ~dt_hold;
  // A frame starts at the first rising edge after arming; bits land on falling edges.
  always @(posedge aclk) begin
    if (ck_oe) ck_hold <= ck_o;
    if (dt_oe) dt_hold <= dt_o;
    ck_prev <= ck_line;
    since <= since + 1;
    if (arm) begin
      cnt <= 0;
      done <= 1'b0;
      seen_rise <= 1'b0;
      word <= 16'h0000;
    end else if (!done) begin
      if (!ck_prev && ck_line) seen_rise <= 1'b1;
      if (ck_prev && !ck_line && seen_rise && dt_oe) begin
        word[cnt] <= dt_line;
        cnt <= cnt + 1;
        period <= since + 1;
        since <= 0;
        if (cnt + 1 == int'(nbits)) done <= 1'b1;
      end
    end
  end
endmodule

// ==== sync_master_serial_tx_bench.sv ====
// Self-checking bench for the synchronous master serial transmitter.
`timescale 1ns/1ps
module sync_master_serial_tx_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rx_done = 1'b0, arm = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [4:0] nbits = 5'h00;
  wire awready, wready, bvalid, arready, rvalid, ck_o, ck_oe, dt_o, dt_oe, irq, done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] word;
  int period;
  int num_errors = 0;
  int checks = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  smstx_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_word_done(rx_done), .serial_clock_line_o(ck_o),
    .serial_clock_line_oe(ck_oe), .serial_data_line_o(dt_o),
    .serial_data_line_oe(dt_oe), .tx_irq(irq));
  smstx_slave_model slave (.aclk(aclk), .ck_o(ck_o), .ck_oe(ck_oe), .dt_o(dt_o),
    .dt_oe(dt_oe), .arm(arm), .nbits(nbits), .word(word), .done(done), .period(period));
  // ************************************************************
  // Clock and shared tasks
  // ************************************************************
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data are offered together and each is dropped when taken.
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    logic ap;
    logic wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic arm_slave(input logic [4:0] n);
    @(posedge aclk);
    arm <= 1'b1;
    nbits <= n;
    @(posedge aclk);
    arm <= 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge aclk);
    chk(32'(done), 32'h0000_0001);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    axr(5'h00); chk(rd, 32'h0000_0002);
    axr(5'h10); chk(rd, 32'h0000_0010);
    chk(32'(irq), 32'h0000_0000);
  endtask
  // Word loaded before enabling, then a second word back to back.
  task automatic t_stream();
    axw(5'h08, 32'h0000_0001);
    axw(5'h00, 32'h0000_0090);
    axw(5'h04, 32'h0000_0080);
    axw(5'h14, 32'h0000_0010);
    axw(5'h0C, 32'h0000_00A5);
    arm_slave(5'h10);
    axw(5'h00, 32'h0000_00B0);
    axw(5'h0C, 32'h0000_003C);
    chk(32'(ck_oe), 32'h0000_0001);
    wait_done();
    chk(32'(word), 32'h0000_3CA5);
    chk(32'(period), 32'h0000_0008);
    repeat (8) @(posedge aclk);
    axr(5'h00); chk(rd, 32'h0000_00B2);
    axr(5'h10); chk(rd, 32'h0000_0010);
    chk(32'(irq), 32'h0000_0001);
    axw(5'h14, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
  endtask
  task automatic t_nine();
    axw(5'h00, 32'h0000_0090);
    axw(5'h00, 32'h0000_00D1);
    axw(5'h0C, 32'h0000_003C);
    arm_slave(5'h09);
    axw(5'h00, 32'h0000_00F1);
    wait_done();
    chk(32'(word), 32'h0000_013C);
  endtask
  task automatic t_abort();
    axw(5'h0C, 32'h0000_00FF);
    repeat (6) @(posedge aclk);
    axw(5'h00, 32'h0000_00D1);
    repeat (2) @(posedge aclk);
    chk(32'(ck_oe), 32'h0000_0000);
    chk(32'(dt_oe), 32'h0000_0000);
    axr(5'h00); chk(rd, 32'h0000_00D3);
  endtask
  task automatic t_rx();
    axw(5'h00, 32'h0000_00B0);
    axw(5'h0C, 32'h0000_0055);
    repeat (8) @(posedge aclk);
    axw(5'h04, 32'h0000_00A0);
    repeat (2) @(posedge aclk);
    chk(32'(dt_oe), 32'h0000_0000);
    chk(32'(ck_oe), 32'h0000_0001);
    rx_done <= 1'b1;
    @(posedge aclk);
    rx_done <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(dt_oe), 32'h0000_0001);
    axr(5'h04); chk(rd, 32'h0000_0080);
    axw(5'h00, 32'h0000_0090);
  endtask
  task automatic t_refuse();
    axr(5'h1C); chk(32'(rsp), 32'h0000_0002);
    chk(rd, 32'h0000_0000);
    axw(5'h1C, 32'h0000_0001); chk(32'(rsp), 32'h0000_0002);
    axw(5'h10, 32'h0000_0000);
    axr(5'h10); chk(rd, 32'h0000_0010);
  endtask
  task automatic final_report();
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The whole sequence needs a few hundred cycles; the limit is well beyond.
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_stream();
    t_nine();
    t_abort();
    t_rx();
    t_refuse();
    final_report();
  end
endmodule
